/* shared/cmcrc_pkg.sv */
// Purpose: shared constants for the configuration memory crc checker
// Assumes: single clock, 32-bit crc, 10-bit jtag instruction register
// Notes: frame length and frame count are parameters of the top module, frame crc width is fixed at 16 bits
package cmcrc_pkg;
    // ------------------------------------------------------------
    // crc constants
    // ------------------------------------------------------------
    localparam logic [31:0] CRC32_POLY = 32'h04C11DB7; // ieee 802 generator
    localparam logic [31:0] CRC32_INIT = 32'hFFFFFFFF; // running crc seed
    localparam logic [15:0] CRC16_POLY = 16'h8005; // frame crc generator
    localparam logic [15:0] CRC16_INIT = 16'hFFFF; // frame crc seed
    localparam logic [31:0] STORE_RST = 32'h00000000; // store value after reset
    localparam logic [31:0] SIG_RST = 32'h00000000; // signature after reset
    // ------------------------------------------------------------
    // jtag instruction codes
    // ------------------------------------------------------------
    localparam int IR_W = 10; // instruction register width
    localparam logic [9:0] IR_LOAD_CHECK = 10'h015; // load check value instruction
    localparam logic [9:0] IR_BYPASS = 10'h3FF; // bypass, value after reset
    // ------------------------------------------------------------
    // phase of operation
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        CMCRC_CONFIG = 2'b00, // receiving configuration frames
        CMCRC_FAIL = 2'b01, // frame crc mismatch, halted
        CMCRC_USER = 2'b10 // user mode, scanning configuration ram
    } cmcrc_phase_t;
endpackage

/* logic/cmcrc_crc_step.sv */
// Purpose: one-bit serial crc step, width parameterised, polynomial from an input
// Assumes: msb-first shift, no reflection
// Notes: pure combinational, shared by frame and user-mode checkers
`timescale 1ns/1ps
module cmcrc_crc_step #(
    parameter int W = 32
) (
    input wire logic [W-1:0] crc_in,
    input wire logic [W-1:0] poly,
    input wire logic bit_in,
    output logic [W-1:0] crc_out
);
    // ------------------------------------------------------------
    // feedback step
    // ------------------------------------------------------------
    logic fb; // feedback bit
    always_comb begin
        fb = crc_in[W-1] ^ bit_in;
        crc_out = {crc_in[W-2:0], 1'b0} ^ (fb ? poly : '0);
    end
endmodule // cmcrc_crc_step

/* logic/cmcrc_checker.sv */
// Purpose: configuration memory crc checker with frame check and user scan
// Assumes: config data and configuration ram bits arrive one bit per clock
// Notes: error flag is open-drain: enable high pulls the pin low, released pin reads as error
// Function
// - check each frame crc during configuration
// - accept frames until mismatch or all done
// - load whole-stream crc into storage at end
// - user mode repeatedly recomputes and compares crc
// - scanning runs until reconfiguration request low
// - only configuration ram bits enter crc
// - single crc32 with ieee 802 polynomial
// - zero signature clears flag, nonzero sets it
// - jtag may overwrite storage to inject errors
// - instruction 00 0001 0101 selects storage register
// - load instruction honoured only in user mode
// - comparisons use registered storage value, a jtag load at pass end counts from next pass
// - error flag active high open-drain
`timescale 1ns/1ps
module cmcrc_checker #(
    parameter int FRAME_BITS = 64, // data bits per configuration frame
    parameter int FRAME_COUNT = 4, // frames in a configuration stream
    parameter int CONFIGURATION_RAM_BITS = 256 // configuration ram bits scanned per pass
) (
    input wire logic CLK_SYS,
    input wire logic ARST_N,
    input wire logic RECONFIG_REQUEST_N, // active-low reconfiguration request
    input wire logic CFG_VALID, // one configuration stream bit this cycle
    input wire logic CFG_BIT,
    input wire logic [31:0] CFG_STREAM_CRC, // whole-stream crc, valid with last frame
    output logic CFG_STATUS_N, // low after frame mismatch
    output logic CFG_DONE, // entered user mode
    output logic [$clog2(CONFIGURATION_RAM_BITS)-1:0] CONFIGURATION_RAM_ADDR, // configuration ram bit index
    input wire logic CONFIGURATION_RAM_BIT, // configuration ram bit at the scan index
    input wire logic TCK_EN, // one-cycle tck rising edge enable
    input wire logic TMS,
    input wire logic TDI,
    output logic TDO,
    output logic TDO_OE,
    output logic ERROR_FLAG_O, // open-drain: level driven when enabled
    output logic ERROR_FLAG_OE,
    output logic [31:0] SIGNATURE // last completed signature
);
    localparam int FCW = $clog2(FRAME_BITS + 16 + 1);
    localparam int NCW = $clog2(FRAME_COUNT + 1);
    localparam int CAW = $clog2(CONFIGURATION_RAM_BITS);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    cmcrc_pkg::cmcrc_phase_t phase_q, phase_d; // configuration phase
    logic [FCW-1:0] fbit_q, fbit_d; // bit position inside frame
    logic [NCW-1:0] fcnt_q, fcnt_d; // frames checked so far
    logic [15:0] fcrc_q, fcrc_d; // running frame crc
    logic [15:0] fexp_q, fexp_d; // embedded frame crc being received
    logic [31:0] store_q, store_d; // check-value storage register
    logic [31:0] ucrc_q, ucrc_d; // running user-mode crc
    logic [CAW-1:0] uaddr_q, uaddr_d; // scan position in configuration ram
    logic [31:0] sig_q, sig_d; // completed signature
    logic err_q, err_d; // error flag
    logic [31:0] ucrc_nxt; // step outputs
    logic [15:0] fcrc_nxt;
    logic frame_end, scan_end; // frame and pass boundaries
    // jtag tap
    typedef enum logic [3:0] {
        CMCRC_TLR = 4'h0, CMCRC_RTI = 4'h1, CMCRC_SDR = 4'h2, CMCRC_CDR = 4'h3,
        CMCRC_SHD = 4'h4, CMCRC_E1D = 4'h5, CMCRC_PDR = 4'h6, CMCRC_E2D = 4'h7,
        CMCRC_UDR = 4'h8, CMCRC_SIR = 4'h9, CMCRC_CIR = 4'hA, CMCRC_SHI = 4'hB,
        CMCRC_E1I = 4'hC, CMCRC_PIR = 4'hD, CMCRC_E2I = 4'hE, CMCRC_UIR = 4'hF
    } cmcrc_tap_t;
    cmcrc_tap_t tap_q, tap_d; // tap controller state
    logic [9:0] ir_q, ir_d, irsh_q, irsh_d; // instruction and its shifter
    logic [31:0] dsh_q, dsh_d; // data shifter for storage register
    logic byp_q, byp_d; // bypass bit
    logic tdo_q, tdo_d, tdoe_q, tdoe_d; // registered tdo
    logic sel_store; // storage register selected
    // ------------------------------------------------------------
    // crc step instances
    // ------------------------------------------------------------
    cmcrc_crc_step #(.W(16)) u_fstep (
        .crc_in(fcrc_q), .poly(cmcrc_pkg::CRC16_POLY), .bit_in(CFG_BIT), .crc_out(fcrc_nxt)
    );
    cmcrc_crc_step #(.W(32)) u_ustep (
        .crc_in(ucrc_q), .poly(cmcrc_pkg::CRC32_POLY), .bit_in(CONFIGURATION_RAM_BIT), .crc_out(ucrc_nxt)
    );
    // ------------------------------------------------------------
    // configuration and user-mode next state
    // ------------------------------------------------------------
    always_comb begin
        phase_d = phase_q;
        fbit_d = fbit_q;
        fcnt_d = fcnt_q;
        fcrc_d = fcrc_q;
        fexp_d = fexp_q;
        store_d = store_q;
        ucrc_d = ucrc_q;
        uaddr_d = uaddr_q;
        sig_d = sig_q;
        err_d = err_q;
        frame_end = 1'b0;
        scan_end = 1'b0;
        unique case (phase_q)
            cmcrc_pkg::CMCRC_CONFIG: begin
                if (CFG_VALID) begin
                    if (fbit_q < FCW'(FRAME_BITS)) begin
                        fcrc_d = fcrc_nxt; // data bits enter frame crc
                    end else begin
                        fexp_d = {fexp_q[14:0], CFG_BIT}; // embedded crc shifts in
                    end
                    fbit_d = fbit_q + FCW'(1);
                    if (fbit_q == FCW'(FRAME_BITS + 15)) begin
                        frame_end = 1'b1;
                        fbit_d = '0;
                        fcrc_d = cmcrc_pkg::CRC16_INIT;
                        fcnt_d = fcnt_q + NCW'(1);
                        if ({fexp_q[14:0], CFG_BIT} != fcrc_q) begin
                            phase_d = cmcrc_pkg::CMCRC_FAIL; // stop on mismatch
                        end else if (fcnt_q == NCW'(FRAME_COUNT - 1)) begin
                            phase_d = cmcrc_pkg::CMCRC_USER; // all frames checked
                            store_d = CFG_STREAM_CRC; // whole-stream crc stored
                        end
                    end
                end
            end
            cmcrc_pkg::CMCRC_FAIL: begin
                phase_d = cmcrc_pkg::CMCRC_FAIL; // held until reconfiguration
            end
            cmcrc_pkg::CMCRC_USER: begin
                // only configuration ram bits feed this crc
                ucrc_d = ucrc_nxt;
                uaddr_d = uaddr_q + CAW'(1);
                if (uaddr_q == CAW'(CONFIGURATION_RAM_BITS - 1)) begin
                    scan_end = 1'b1;
                    uaddr_d = '0; // wrap and rescan endlessly
                    ucrc_d = cmcrc_pkg::CRC32_INIT;
                    sig_d = ucrc_nxt ^ store_q; // compare with stored value
                    err_d = (ucrc_nxt ^ store_q) != 32'h00000000;
                end
                if (tap_q == CMCRC_UDR && TCK_EN && sel_store) begin
                    store_d = dsh_q; // jtag overwrite in user mode only
                end
            end
            default: begin
                phase_d = cmcrc_pkg::CMCRC_CONFIG;
            end
        endcase
    end
    // ------------------------------------------------------------
    // checker registers, cleared by reconfiguration request
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            phase_q <= cmcrc_pkg::CMCRC_CONFIG;
            fbit_q <= '0;
            fcnt_q <= '0;
            fcrc_q <= cmcrc_pkg::CRC16_INIT;
            fexp_q <= 16'h0000;
            store_q <= cmcrc_pkg::STORE_RST;
            ucrc_q <= cmcrc_pkg::CRC32_INIT;
            uaddr_q <= '0;
            sig_q <= cmcrc_pkg::SIG_RST;
            err_q <= 1'b0;
        end else if (!RECONFIG_REQUEST_N) begin
            // synchronous clear: stops scanning and restarts configuration
            phase_q <= cmcrc_pkg::CMCRC_CONFIG;
            fbit_q <= '0;
            fcnt_q <= '0;
            fcrc_q <= cmcrc_pkg::CRC16_INIT;
            fexp_q <= 16'h0000;
            store_q <= cmcrc_pkg::STORE_RST;
            ucrc_q <= cmcrc_pkg::CRC32_INIT;
            uaddr_q <= '0;
            sig_q <= cmcrc_pkg::SIG_RST;
            err_q <= 1'b0;
        end else begin
            phase_q <= phase_d;
            fbit_q <= fbit_d;
            fcnt_q <= fcnt_d;
            fcrc_q <= fcrc_d;
            fexp_q <= fexp_d;
            store_q <= store_d;
            ucrc_q <= ucrc_d;
            uaddr_q <= uaddr_d;
            sig_q <= sig_d;
            err_q <= err_d;
        end
    end
    // ------------------------------------------------------------
    // jtag tap next state
    // ------------------------------------------------------------
    assign sel_store = (ir_q == cmcrc_pkg::IR_LOAD_CHECK);
    always_comb begin
        tap_d = tap_q;
        ir_d = ir_q;
        irsh_d = irsh_q;
        dsh_d = dsh_q;
        byp_d = byp_q;
        tdo_d = tdo_q;
        tdoe_d = tdoe_q;
        if (TCK_EN) begin
            unique case (tap_q)
                CMCRC_TLR: tap_d = TMS ? CMCRC_TLR : CMCRC_RTI;
                CMCRC_RTI: tap_d = TMS ? CMCRC_SDR : CMCRC_RTI;
                CMCRC_SDR: tap_d = TMS ? CMCRC_SIR : CMCRC_CDR;
                CMCRC_CDR: tap_d = TMS ? CMCRC_E1D : CMCRC_SHD;
                CMCRC_SHD: tap_d = TMS ? CMCRC_E1D : CMCRC_SHD;
                CMCRC_E1D: tap_d = TMS ? CMCRC_UDR : CMCRC_PDR;
                CMCRC_PDR: tap_d = TMS ? CMCRC_E2D : CMCRC_PDR;
                CMCRC_E2D: tap_d = TMS ? CMCRC_UDR : CMCRC_SHD;
                CMCRC_UDR: tap_d = TMS ? CMCRC_SDR : CMCRC_RTI;
                CMCRC_SIR: tap_d = TMS ? CMCRC_TLR : CMCRC_CIR;
                CMCRC_CIR: tap_d = TMS ? CMCRC_E1I : CMCRC_SHI;
                CMCRC_SHI: tap_d = TMS ? CMCRC_E1I : CMCRC_SHI;
                CMCRC_E1I: tap_d = TMS ? CMCRC_UIR : CMCRC_PIR;
                CMCRC_PIR: tap_d = TMS ? CMCRC_E2I : CMCRC_PIR;
                CMCRC_E2I: tap_d = TMS ? CMCRC_UIR : CMCRC_SHI;
                CMCRC_UIR: tap_d = TMS ? CMCRC_SDR : CMCRC_RTI;
            endcase
            unique case (tap_q)
                CMCRC_TLR: ir_d = cmcrc_pkg::IR_BYPASS;
                CMCRC_CIR: irsh_d = 10'h001; // capture pattern
                CMCRC_SHI: begin
                    tdo_d = irsh_q[0];
                    irsh_d = {TDI, irsh_q[9:1]};
                end
                CMCRC_UIR: ir_d = irsh_q;
                CMCRC_CDR: begin
                    dsh_d = store_q; // readout of current stored value first
                    byp_d = 1'b0;
                end
                CMCRC_SHD: begin
                    tdo_d = sel_store ? dsh_q[0] : byp_q; // lsb first
                    dsh_d = {TDI, dsh_q[31:1]};
                    byp_d = TDI;
                end
                default: begin
                    ir_d = ir_q;
                end
            endcase
            tdoe_d = (tap_q == CMCRC_SHD) || (tap_q == CMCRC_SHI);
        end
    end
    // ------------------------------------------------------------
    // jtag registers
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            tap_q <= CMCRC_TLR;
            ir_q <= cmcrc_pkg::IR_BYPASS;
            irsh_q <= 10'h000;
            dsh_q <= 32'h00000000;
            byp_q <= 1'b0;
            tdo_q <= 1'b0;
            tdoe_q <= 1'b0;
        end else begin
            tap_q <= tap_d;
            ir_q <= ir_d;
            irsh_q <= irsh_d;
            dsh_q <= dsh_d;
            byp_q <= byp_d;
            tdo_q <= tdo_d;
            tdoe_q <= tdoe_d;
        end
    end
    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign CFG_STATUS_N = (phase_q != cmcrc_pkg::CMCRC_FAIL);
    assign CFG_DONE = (phase_q == cmcrc_pkg::CMCRC_USER);
    assign CONFIGURATION_RAM_ADDR = uaddr_q;
    assign TDO = tdo_q;
    assign TDO_OE = tdoe_q;
    assign SIGNATURE = sig_q;
    // open-drain: never drive high, release lets pull-up show high
    assign ERROR_FLAG_O = 1'b0;
    assign ERROR_FLAG_OE = ~err_q; // pulled low while no error
    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_flag_after_pass;
        @(posedge CLK_SYS) disable iff (!ARST_N)
        (scan_end && RECONFIG_REQUEST_N) |=> (err_q == (sig_q != 32'h00000000));
    endproperty
    a_flag_after_pass: assert property (p_flag_after_pass) else $error("flag disagrees with signature");
    property p_flag_hold;
        @(posedge CLK_SYS) disable iff (!ARST_N)
        (!scan_end && RECONFIG_REQUEST_N) |=> $stable(err_q);
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flag changed between passes");
    property p_reconfig_clear;
        @(posedge CLK_SYS) disable iff (!ARST_N)
        !RECONFIG_REQUEST_N |=> (!err_q && phase_q == cmcrc_pkg::CMCRC_CONFIG);
    endproperty
    a_reconfig_clear: assert property (p_reconfig_clear) else $error("reconfiguration did not clear");
    property p_no_load_in_config;
        @(posedge CLK_SYS) disable iff (!ARST_N)
        (phase_q != cmcrc_pkg::CMCRC_USER && !frame_end && RECONFIG_REQUEST_N) |=> $stable(store_q);
    endproperty
    a_no_load_in_config: assert property (p_no_load_in_config) else $error("store changed outside user mode");
    property p_jtag_load;
        @(posedge CLK_SYS) disable iff (!ARST_N)
        (CFG_DONE && tap_q == CMCRC_UDR && TCK_EN && sel_store && RECONFIG_REQUEST_N) |=> (store_q == $past(dsh_q));
    endproperty
    a_jtag_load: assert property (p_jtag_load) else $error("jtag load not taken");
    property p_stream_load;
        @(posedge CLK_SYS) disable iff (!ARST_N)
        (frame_end && phase_d == cmcrc_pkg::CMCRC_USER && RECONFIG_REQUEST_N) |=> (store_q == $past(CFG_STREAM_CRC));
    endproperty
    a_stream_load: assert property (p_stream_load) else $error("stream crc not stored");
    property p_fail_sticky;
        @(posedge CLK_SYS) disable iff (!ARST_N)
        (phase_q == cmcrc_pkg::CMCRC_FAIL && RECONFIG_REQUEST_N) |=> (phase_q == cmcrc_pkg::CMCRC_FAIL);
    endproperty
    a_fail_sticky: assert property (p_fail_sticky) else $error("left failure without reconfiguration");
    sequence s_user_step;
        CFG_DONE && RECONFIG_REQUEST_N;
    endsequence
    property p_scan_advance;
        @(posedge CLK_SYS) disable iff (!ARST_N)
        s_user_step ##1 s_user_step |->
            (($past(uaddr_q) == CAW'(CONFIGURATION_RAM_BITS - 1)) ? (uaddr_q == '0)
                : (uaddr_q == CAW'($past(uaddr_q) + 1)));
    endproperty
    a_scan_advance: assert property (p_scan_advance) else $error("scan stalled");
endmodule // cmcrc_checker

/* test/cmcrc_far_model.sv */
// Purpose: far-side model, configuration ram image and pin wiring
// Assumes: ram bit is returned in the same cycle as the scan address
// Notes: error pin has a pull-up; tdo floats when the checker releases it
`timescale 1ns/1ps
module cmcrc_far_model #(
    parameter int CONFIGURATION_RAM_BITS = 16
) (
    input wire logic clk_sys,
    input wire logic [CONFIGURATION_RAM_BITS-1:0] configuration_ram_image, // ram contents set by the bench
    input wire logic [$clog2(CONFIGURATION_RAM_BITS)-1:0] configuration_ram_addr,
    output logic configuration_ram_bit,
    input wire logic tdo,
    input wire logic tdo_oe,
    output logic tdo_line, // resolved tdo wire
    input wire logic flag_o,
    input wire logic flag_oe,
    output logic flag_line // resolved error pin
);
    logic tdo_last = 1'b0; // last driven tdo level
    // ----------------------------------------
    // wiring
    // ----------------------------------------
    // only ram cells feed the scan, no block memory or io storage
    assign configuration_ram_bit = configuration_ram_image[configuration_ram_addr];
    // pull-up: a released pin reads high, which means error
    assign flag_line = flag_oe ? flag_o : 1'b1;
    // a floating tdo shows the inverse, so stale data never matches by luck
    always_ff @(posedge clk_sys) begin
        if (tdo_oe) begin
            tdo_last <= tdo;
        end
    end
    assign tdo_line = tdo_oe ? tdo : ~tdo_last;
endmodule // cmcrc_far_model

/* test/config_memory_crc_checker_test.sv */
// Purpose: self-checking bench for the configuration memory crc checker
// Assumes: small counts (8-bit frames, 2 frames, 16 ram bits)
// Notes: inputs change on the falling edge; expectations from local crc functions
`timescale 1ns/1ps
module config_memory_crc_checker_test;
    localparam int FB = 8; // frame data bits
    localparam int FC = 2; // frames per stream
    localparam int CB = 16; // ram bits per pass
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic reconfig_n = 1'b1;
    logic cfg_valid = 1'b0;
    logic cfg_bit = 1'b0;
    logic [31:0] stream_crc = 32'h0;
    logic tck_en = 1'b0;
    logic tms = 1'b1;
    logic tdi = 1'b0;
    logic [CB-1:0] configuration_ram_image = 16'h0;
    logic cfg_status_n, cfg_done, configuration_ram_bit, tdo, tdo_oe, flag_o, flag_oe, tdo_line, flag_line;
    logic [3:0] configuration_ram_addr;
    logic [31:0] signature, good_crc, bad_val, rd;
    int seed = 5372;
    int mismatches = 0;
    int n_tests = 0;
    int cycles = 0;
    int idx;
    always #50 clk_sys = ~clk_sys;
    // ----------------------------------------
    // design and far side
    // ----------------------------------------
    cmcrc_checker #(.FRAME_BITS(FB), .FRAME_COUNT(FC), .CONFIGURATION_RAM_BITS(CB)) cmcrc_checker_inst (
        .CLK_SYS(clk_sys), .ARST_N(arst_n), .RECONFIG_REQUEST_N(reconfig_n), .CFG_VALID(cfg_valid),
        .CFG_BIT(cfg_bit), .CFG_STREAM_CRC(stream_crc), .CFG_STATUS_N(cfg_status_n), .CFG_DONE(cfg_done),
        .CONFIGURATION_RAM_ADDR(configuration_ram_addr), .CONFIGURATION_RAM_BIT(configuration_ram_bit),
        .TCK_EN(tck_en), .TMS(tms), .TDI(tdi), .TDO(tdo),
        .TDO_OE(tdo_oe), .ERROR_FLAG_O(flag_o), .ERROR_FLAG_OE(flag_oe), .SIGNATURE(signature));
    cmcrc_far_model #(.CONFIGURATION_RAM_BITS(CB)) cmcrc_far_model_inst (
        .clk_sys(clk_sys), .configuration_ram_image(configuration_ram_image),
        .configuration_ram_addr(configuration_ram_addr), .configuration_ram_bit(configuration_ram_bit),
        .tdo(tdo), .tdo_oe(tdo_oe), .tdo_line(tdo_line), .flag_o(flag_o), .flag_oe(flag_oe),
        .flag_line(flag_line));
    // ----------------------------------------
    // expectation functions
    // ----------------------------------------
    // frame crc, msb first, fresh seed per frame
    function automatic logic [15:0] f_crc16(input logic [FB-1:0] d);
        logic [15:0] c;
        c = cmcrc_pkg::CRC16_INIT;
        for (int i = FB - 1; i >= 0; i--) begin
            c = (c[15] ^ d[i]) ? ({c[14:0], 1'b0} ^ cmcrc_pkg::CRC16_POLY) : {c[14:0], 1'b0};
        end
        return c;
    endfunction
    // ram crc in scan order, address 0 first
    function automatic logic [31:0] f_crc32(input logic [CB-1:0] m);
        logic [31:0] c;
        c = cmcrc_pkg::CRC32_INIT;
        for (int i = 0; i < CB; i++) begin
            c = (c[31] ^ m[i]) ? ({c[30:0], 1'b0} ^ cmcrc_pkg::CRC32_POLY) : {c[30:0], 1'b0};
        end
        return c;
    endfunction
    // ----------------------------------------
    // tasks, entered at a falling edge except test_done from the hang guard
    // ----------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask
    // random frames; bad corrupts the first embedded crc
    task automatic configure(input logic bad);
        logic [FB+15:0] w;
        for (int f = 0; f < FC; f++) begin
            w[FB+15:16] = FB'($random(seed));
            w[15:0] = f_crc16(w[FB+15:16]) ^ ((bad && f == 0) ? 16'h0001 : 16'h0000);
            for (int i = FB + 15; i >= 0; i--) begin
                cfg_valid = 1'b1;
                cfg_bit = w[i];
                @(negedge clk_sys);
            end
        end
        cfg_valid = 1'b0;
        repeat (2) @(negedge clk_sys);
    endtask
    task automatic tstep(input logic m, input logic i, output logic o);
        o = tdo_line;
        tms = m;
        tdi = i;
        tck_en = 1'b1;
        @(negedge clk_sys);
    endtask
    // full scan: reset tap, load instruction, swap 32-bit store value
    task automatic jtag_dr(input logic [31:0] din, output logic [31:0] dout);
        logic o;
        logic [9:0] ir;
        ir = cmcrc_pkg::IR_LOAD_CHECK;
        repeat (5) tstep(1'b1, 1'b0, o);
        tstep(1'b0, 1'b0, o);
        tstep(1'b1, 1'b0, o);
        tstep(1'b1, 1'b0, o);
        tstep(1'b0, 1'b0, o);
        tstep(1'b0, 1'b0, o);
        for (int i = 0; i < 10; i++) tstep(i == 9, ir[i], o);
        tstep(1'b1, 1'b0, o);
        tstep(1'b1, 1'b0, o);
        tstep(1'b0, 1'b0, o);
        tstep(1'b0, 1'b0, o);
        // tdo is registered, so each bit shows one step after its shift edge
        for (int i = 0; i < 32; i++) begin
            tstep(i == 31, din[i], o);
            if (i > 0) begin
                dout[i - 1] = o;
            end
        end
        tstep(1'b1, 1'b0, dout[31]);
        tstep(1'b0, 1'b0, o);
        tck_en = 1'b0;
        @(negedge clk_sys);
    endtask
    // pulse the reconfiguration request low
    task automatic reconfig();
        reconfig_n = 1'b0;
        repeat (2) @(negedge clk_sys);
        reconfig_n = 1'b1;
        @(negedge clk_sys);
    endtask
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // hang guard, far above the expected run length
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 4000) begin
            mismatches++;
            test_done();
        end
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (6) @(negedge clk_sys);
        arst_n = 1'b1;
        chk("status_n", 32'h1, {31'h0, cfg_status_n});
        chk("flag", 32'h0, {31'h0, flag_line});
        $display("test reset ended");
        stream_crc = 32'($random(seed));
        configure(1'b1);
        chk("status_n bad frame", 32'h0, {31'h0, cfg_status_n});
        chk("done bad frame", 32'h0, {31'h0, cfg_done});
        jtag_dr(32'($random(seed)), rd);
        jtag_dr(32'h0, rd);
        chk("store outside user", cmcrc_pkg::STORE_RST, rd);
        $display("test bad frame ended");
        reconfig();
        configuration_ram_image = CB'($random(seed));
        good_crc = f_crc32(configuration_ram_image);
        stream_crc = good_crc;
        configure(1'b0);
        chk("done", 32'h1, {31'h0, cfg_done});
        chk("status_n", 32'h1, {31'h0, cfg_status_n});
        repeat (40) @(negedge clk_sys);
        chk("signature clean", 32'h0, signature);
        chk("flag clean", 32'h0, {31'h0, flag_line});
        $display("test good config ended");
        bad_val = good_crc ^ (32'($random(seed)) | 32'h1);
        jtag_dr(bad_val, rd);
        chk("stored crc", good_crc, rd);
        repeat (40) @(negedge clk_sys);
        chk("signature injected", good_crc ^ bad_val, signature);
        chk("flag injected", 32'h1, {31'h0, flag_line});
        jtag_dr(good_crc, rd);
        chk("store readback", bad_val, rd);
        repeat (40) @(negedge clk_sys);
        chk("flag restored", 32'h0, {31'h0, flag_line});
        $display("test injection ended");
        idx = {$random(seed)} % CB;
        configuration_ram_image[idx] = ~configuration_ram_image[idx];
        repeat (40) @(negedge clk_sys);
        chk("signature upset", f_crc32(configuration_ram_image) ^ good_crc, signature);
        repeat (20) @(negedge clk_sys);
        chk("flag upset", 32'h1, {31'h0, flag_line});
        reconfig();
        chk("flag after reconfig", 32'h0, {31'h0, flag_line});
        chk("done after reconfig", 32'h0, {31'h0, cfg_done});
        chk("signature after reconfig", cmcrc_pkg::SIG_RST, signature);
        $display("test upset ended");
        test_done();
    end
endmodule // config_memory_crc_checker_test
